/* File: core/qhdp_pkg.sv */
// Package: register map, access sizes and carriers of the queue host data port
package qhdp_pkg;

  localparam int unsigned PTR_W = 11;

  // Register byte offsets within the bank
  localparam logic [3:0] OFS_TX_CMD   = 4'h0;
  localparam logic [3:0] OFS_RX_CMD   = 4'h2;
  localparam logic [3:0] OFS_TX_PTR   = 4'h4;
  localparam logic [3:0] OFS_RX_PTR   = 4'h6;
  localparam logic [3:0] OFS_DATA_LO  = 4'h8;
  localparam logic [3:0] OFS_DATA_HI  = 4'hA;

  // Field positions
  localparam int unsigned BIT_AUTO_INC = 14;
  localparam int unsigned BIT_CMD      = 0;

  localparam logic [PTR_W-1:0] PTR_RESET = 11'h000;
  localparam logic [15:0]      ZERO16    = 16'h0000;

  // Pointer advance per access size
  localparam logic [PTR_W-1:0] STEP_BYTE  = 11'h001;
  localparam logic [PTR_W-1:0] STEP_WORD  = 11'h002;
  localparam logic [PTR_W-1:0] STEP_DWORD = 11'h004;

  // Queue address offset of the high data word
  localparam logic [PTR_W-1:0] OFS_HI_WORD = 11'h002;
  localparam logic [PTR_W-1:0] OFS_NONE    = 11'h000;

  // Byte lanes per access size
  localparam logic [3:0] LANES_BYTE  = 4'h1;
  localparam logic [3:0] LANES_WORD  = 4'h3;
  localparam logic [3:0] LANES_DWORD = 4'hF;

  typedef enum logic [1:0] {
    SIZE_BYTE  = 2'h0,
    SIZE_WORD  = 2'h1,
    SIZE_DWORD = 2'h2
  } qhdp_size_type;

  // Host bus request
  typedef struct packed {
    logic          rd;
    logic          wr;
    logic [3:0]    addr;
    qhdp_size_type size;
    logic [31:0]   wdata;
  } qhdp_req_type;

  // Queue memory byte-lane access
  typedef struct packed {
    logic             en;
    logic [PTR_W-1:0] addr;
    logic [3:0]       lanes;
    logic [31:0]      data;
  } qhdp_mem_type;

endpackage

/* File: core/qhdp_ptr.sv */
// Frame pointer with auto-increment, command reload and self-clearing command bit
`timescale 1ns/100ps
module qhdp_ptr
  import qhdp_pkg::*;
(
  input  wire logic             clock,
  input  wire logic             sys_rst,
  input  wire logic             ptr_wr,
  input  wire logic [15:0]      ptr_wdata,
  input  wire logic             data_acc,
  input  wire qhdp_size_type    size,
  input  wire logic             cmd_wr,
  input  wire logic             cmd_done,
  input  wire logic [PTR_W-1:0] next_loc,
  output logic [PTR_W-1:0]      ptr,
  output logic                  auto_inc,
  output logic                  cmd_busy
);
  import qhdp_pkg::*;

  logic [PTR_W-1:0] ptr_q, ptr_d;
  logic             auto_q, auto_d;
  logic             busy_q, busy_d;
  logic [PTR_W-1:0] step;

  always_comb begin
    unique case (size)
      SIZE_BYTE:  step = STEP_BYTE;
      SIZE_WORD:  step = STEP_WORD;
      SIZE_DWORD: step = STEP_DWORD;
      default:    step = STEP_BYTE;
    endcase
  end

  always_comb begin
    ptr_d  = ptr_q;
    auto_d = auto_q;
    busy_d = busy_q;
    if (ptr_wr) begin
      ptr_d  = ptr_wdata[PTR_W-1:0];
      auto_d = ptr_wdata[BIT_AUTO_INC];
    end else if (cmd_done) begin
      ptr_d = next_loc;
    end else if (data_acc && auto_q) begin
      ptr_d = ptr_q + step;
    end
    // Otherwise held still
    if (cmd_wr) begin
      busy_d = 1'b1;
    end else if (cmd_done) begin
      busy_d = 1'b0;
    end
  end

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      ptr_q  <= PTR_RESET;
      auto_q <= 1'b0;
      busy_q <= 1'b0;
    end else begin
      ptr_q  <= ptr_d;
      auto_q <= auto_d;
      busy_q <= busy_d;
    end
  end

  assign ptr      = ptr_q;
  assign auto_inc = auto_q;
  assign cmd_busy = busy_q;

endmodule

/* File: core/qhdp_top.sv */
// Host data port into the receive and transmit frame queues
// Functional notes
// - Auto-increment advances rx pointer on data reads
// - Advance equals access size: 1, 2, 4
// - Auto-increment off: pointer held, host writes it
// - Rx pointer is 11-bit RW, resets zero
// - Release command reloads pointer to next frame
// - Data read from receive queue, write to transmit
// - Any alignment, mixed access sizes accepted
// - Low/high words consecutive; one dword location
// - Separate one-way read and write buffers
// - Release bit self-clears when memory freed
// - Tx pointer advances on writes, reloads on enqueue
`timescale 1ns/100ps
module qhdp_top
  import qhdp_pkg::*;
(
  input  wire logic             clock,
  input  wire logic             sys_rst,
  input  wire qhdp_req_type     host_req,
  output logic [31:0]           host_rdata,
  output logic                  host_rvalid,
  // Receive queue read port, read data taken in the same cycle the port is driven
  output qhdp_mem_type          receive_queue_rd,
  input  wire logic [31:0]      receive_queue_rdata,
  // Transmit queue write port
  output qhdp_mem_type          transmit_queue_wr,
  // Queue management unit links
  output logic                  rx_release_req,
  input  wire logic             rx_release_done,
  input  wire logic [PTR_W-1:0] rx_next_loc,
  output logic                  tx_enqueue_req,
  input  wire logic             tx_enqueue_done,
  input  wire logic [PTR_W-1:0] tx_next_loc
);
  import qhdp_pkg::*;

  // ==========================================================
  // Address decode
  logic       hit_lo, hit_hi, data_rd, data_wr;
  logic       rx_ptr_wr, tx_ptr_wr, rx_cmd_wr, tx_cmd_wr;
  logic [3:0] lanes;
  logic [PTR_W-1:0] sub;

  always_comb begin
    hit_lo    = host_req.addr == OFS_DATA_LO;
    hit_hi    = host_req.addr == OFS_DATA_HI;
    data_rd   = host_req.rd && (hit_lo || hit_hi);
    data_wr   = host_req.wr && (hit_lo || hit_hi);
    rx_ptr_wr = host_req.wr && host_req.addr == OFS_RX_PTR;
    tx_ptr_wr = host_req.wr && host_req.addr == OFS_TX_PTR;
    rx_cmd_wr = host_req.wr && host_req.addr == OFS_RX_CMD && host_req.wdata[BIT_CMD];
    tx_cmd_wr = host_req.wr && host_req.addr == OFS_TX_CMD && host_req.wdata[BIT_CMD];
  end

  // ==========================================================
  // Pointers
  logic [PTR_W-1:0] rx_ptr, tx_ptr;
  logic             rx_auto, tx_auto, rx_busy, tx_busy;

  qhdp_ptr u_rx_ptr (
    .clock    (clock),
    .sys_rst  (sys_rst),
    .ptr_wr   (rx_ptr_wr),
    .ptr_wdata(host_req.wdata[15:0]),
    .data_acc (data_rd),
    .size     (host_req.size),
    .cmd_wr   (rx_cmd_wr),
    .cmd_done (rx_release_done),
    .next_loc (rx_next_loc),
    .ptr      (rx_ptr),
    .auto_inc (rx_auto),
    .cmd_busy (rx_busy)
  );

  qhdp_ptr u_tx_ptr (
    .clock    (clock),
    .sys_rst  (sys_rst),
    .ptr_wr   (tx_ptr_wr),
    .ptr_wdata(host_req.wdata[15:0]),
    .data_acc (data_wr),
    .size     (host_req.size),
    .cmd_wr   (tx_cmd_wr),
    .cmd_done (tx_enqueue_done),
    .next_loc (tx_next_loc),
    .ptr      (tx_ptr),
    .auto_inc (tx_auto),
    .cmd_busy (tx_busy)
  );

  // ==========================================================
  // Byte lanes: high word offset adds two bytes
  always_comb begin
    sub = hit_hi ? OFS_HI_WORD : OFS_NONE;
    unique case (host_req.size)
      SIZE_BYTE:  lanes = LANES_BYTE;
      SIZE_WORD:  lanes = LANES_WORD;
      SIZE_DWORD: lanes = LANES_DWORD;
      default:    lanes = LANES_BYTE;
    endcase
  end

  // ==========================================================
  // Queue ports and one-way data buffers
  qhdp_mem_type rdp_q, rdp_d, wrp_q, wrp_d;
  logic         rd_pend_q, rd_pend_d;
  logic [31:0]  rbuf_q, rbuf_d;
  logic         rval_q, rval_d;
  logic         rel_q, rel_d, enq_q, enq_d;
  logic [15:0]  reg_rdata;

  always_comb begin
    reg_rdata = ZERO16;
    unique case (host_req.addr)
      OFS_RX_PTR: begin
        reg_rdata[PTR_W-1:0]   = rx_ptr;
        reg_rdata[BIT_AUTO_INC] = rx_auto;
      end
      OFS_TX_PTR: begin
        reg_rdata[PTR_W-1:0]   = tx_ptr;
        reg_rdata[BIT_AUTO_INC] = tx_auto;
      end
      OFS_RX_CMD: reg_rdata[BIT_CMD] = rx_busy;
      OFS_TX_CMD: reg_rdata[BIT_CMD] = tx_busy;
      default:    reg_rdata = ZERO16;
    endcase
  end

  always_comb begin
    rdp_d       = '0;
    rdp_d.en    = data_rd;
    rdp_d.addr  = rx_ptr + sub;
    rdp_d.lanes = lanes;
    wrp_d       = '0;
    wrp_d.en    = data_wr;
    wrp_d.addr  = tx_ptr + sub;
    wrp_d.lanes = lanes;
    wrp_d.data  = host_req.wdata;
    rd_pend_d   = data_rd;
    rbuf_d      = rbuf_q;
    rval_d      = 1'b0;
    if (rd_pend_q) begin
      rbuf_d = receive_queue_rdata;
      rval_d = 1'b1;
    end else if (host_req.rd && !data_rd) begin
      rbuf_d = {ZERO16, reg_rdata};
      rval_d = 1'b1;
    end
    rel_d = rx_cmd_wr;
    enq_d = tx_cmd_wr;
  end

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      rdp_q     <= '0;
      wrp_q     <= '0;
      rd_pend_q <= 1'b0;
      rbuf_q    <= '0;
      rval_q    <= 1'b0;
      rel_q     <= 1'b0;
      enq_q     <= 1'b0;
    end else begin
      rdp_q     <= rdp_d;
      wrp_q     <= wrp_d;
      rd_pend_q <= rd_pend_d;
      rbuf_q    <= rbuf_d;
      rval_q    <= rval_d;
      rel_q     <= rel_d;
      enq_q     <= enq_d;
    end
  end

  assign receive_queue_rd  = rdp_q;
  assign transmit_queue_wr = wrp_q;
  assign host_rdata        = rbuf_q;
  assign host_rvalid       = rval_q;
  assign rx_release_req    = rel_q;
  assign tx_enqueue_req    = enq_q;

endmodule

/* File: tb/qhdp_qmu_model.sv */
// Partner: queue memory and queue manager behind the port
`timescale 1ns/100ps
module qhdp_queue_model
  import qhdp_pkg::*;
(
  input wire logic         clock,
  input wire logic         sys_rst,
  input wire qhdp_mem_type receive_queue_rd,
  output logic [31:0]      receive_queue_rdata,
  input wire logic         rx_release_req,
  output logic             rx_release_done,
  output logic [PTR_W-1:0] rx_next_loc,
  input wire logic         tx_enqueue_req,
  output logic             tx_enqueue_done,
  output logic [PTR_W-1:0] tx_next_loc
);
  logic [7:0] b;
  logic [7:0] a_q;
  logic       hold_q;
  logic [7:0] rel_q;
  logic [7:0] enq_q;
  // ==========
  // Byte k of the queue holds its own address
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      a_q <= 8'h00;
      hold_q <= 1'b0;
      rel_q <= 8'h00;
      enq_q <= 8'h00;
    end else begin
      a_q <= b;
      hold_q <= receive_queue_rd.en;
      rel_q <= {rel_q[6:0], rx_release_req};
      enq_q <= {enq_q[6:0], tx_enqueue_req};
    end
  end
  assign b = receive_queue_rd.en ? receive_queue_rd.addr[7:0] : a_q;
  // Stale data inverted once the read is over
  assign receive_queue_rdata = {b + 8'h03, b + 8'h02, b + 8'h01, b} ^ {32{~(receive_queue_rd.en | hold_q)}};
  assign rx_release_done = rel_q[7];
  assign rx_next_loc = 11'h123;
  assign tx_enqueue_done = enq_q[7];
  assign tx_next_loc = 11'h040;
endmodule

/* File: tb/qhdp_top_sva.sv */
// Checker: port assertions of the queue host data port
`timescale 1ns/100ps
module qhdp_top_sva
  import qhdp_pkg::*;
(
  input wire logic         clock,
  input wire logic         sys_rst,
  input wire qhdp_req_type host_req,
  input wire logic         host_rvalid,
  input wire qhdp_mem_type receive_queue_rd,
  input wire qhdp_mem_type transmit_queue_wr,
  input wire logic         rx_release_req,
  input wire logic         rx_release_done,
  input wire logic         tx_enqueue_req
);
  default clocking @(posedge clock); endclocking
  default disable iff (sys_rst);
  logic dat;
  logic cmd;
  assign dat = host_req.addr inside {OFS_DATA_LO, OFS_DATA_HI};
  assign cmd = host_req.wr && host_req.wdata[BIT_CMD];
  // ==========
  // Assertions
  rx_fetch_a: assert property (host_req.rd && dat |=> receive_queue_rd.en) else $error("no fetch");
  rd_answer_a: assert property (receive_queue_rd.en |=> host_rvalid) else $error("no answer");
  reg_answer_a: assert property (host_req.rd && !dat && !receive_queue_rd.en |=> host_rvalid)
    else $error("no register answer");
  tx_store_a: assert property (host_req.wr && dat |=> transmit_queue_wr.en) else $error("no store");
  tx_data_a: assert property (host_req.wr && dat |=> transmit_queue_wr.data == $past(host_req.wdata))
    else $error("store data");
  rd_dir_a: assert property (host_req.rd |=> !transmit_queue_wr.en) else $error("read stored");
  wr_dir_a: assert property (host_req.wr |=> !receive_queue_rd.en) else $error("write fetched");
  dw_lanes_a: assert property (host_req.rd && dat && host_req.size == SIZE_DWORD |=> receive_queue_rd.lanes == LANES_DWORD)
    else $error("lanes");
  release_req_a: assert property (cmd && host_req.addr == OFS_RX_CMD |=> rx_release_req) else $error("release");
  enqueue_req_a: assert property (cmd && host_req.addr == OFS_TX_CMD |=> tx_enqueue_req) else $error("enqueue");
  cover property (rx_release_done);
  cover property (transmit_queue_wr.en);
  cover property (host_rvalid);
  cover property (rx_release_req);
endmodule
bind qhdp_top qhdp_top_sva chk (.clock(clock), .sys_rst(sys_rst), .host_req(host_req), .host_rvalid(host_rvalid),
  .receive_queue_rd(receive_queue_rd), .transmit_queue_wr(transmit_queue_wr), .rx_release_req(rx_release_req),
  .rx_release_done(rx_release_done), .tx_enqueue_req(tx_enqueue_req));

/* File: tb/queue_host_data_port_tb_top.sv */
// Testbench: register and queue data accesses of the host data port
`timescale 1ns/100ps
module queue_host_data_port_tb_top;
  import qhdp_pkg::*;
  logic clock = 0;
  logic sys_rst = 1;
  qhdp_req_type host_req = '0;
  qhdp_mem_type receive_queue_rd, transmit_queue_wr, t;
  logic [31:0] host_rdata, receive_queue_rdata, d;
  logic host_rvalid, rx_release_req, rx_release_done, tx_enqueue_req, tx_enqueue_done;
  logic [PTR_W-1:0] rx_next_loc, tx_next_loc;
  int num_errors = 0;
  int num_checks = 0;
  qhdp_top dut (.clock, .sys_rst, .host_req, .host_rdata, .host_rvalid, .receive_queue_rd, .receive_queue_rdata,
    .transmit_queue_wr, .rx_release_req, .rx_release_done, .rx_next_loc, .tx_enqueue_req, .tx_enqueue_done,
    .tx_next_loc);
  qhdp_queue_model qmodel (.clock, .sys_rst, .receive_queue_rd, .receive_queue_rdata, .rx_release_req,
    .rx_release_done, .rx_next_loc, .tx_enqueue_req, .tx_enqueue_done, .tx_next_loc);
  initial forever #2 clock = ~clock;
  // ==========
  // Bus tasks
  task automatic acc(logic r, logic [3:0] a, qhdp_size_type s, logic [31:0] wd);
    @(posedge clock);
    host_req <= '{r, ~r, a, s, wd};
    @(posedge clock);
    host_req <= '0;
    d = 'x;
    t = '0;
    repeat (4) begin
      @(negedge clock);
      if (host_rvalid === 1'b1) d = host_rdata;
      if (transmit_queue_wr.en === 1'b1) t = transmit_queue_wr;
    end
  endtask
  task automatic chk(logic [31:0] got, logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic summarize;
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  initial begin
    repeat (4) @(posedge clock);
    sys_rst <= 0;
    acc(1, OFS_RX_PTR, SIZE_WORD, 0); chk(d[15:0], 16'h0000);
    acc(0, OFS_RX_PTR, SIZE_WORD, 32'h0000_47FE);
    acc(1, OFS_DATA_LO, SIZE_WORD, 0); chk(d[15:0], 16'hFFFE);
    acc(1, OFS_RX_PTR, SIZE_WORD, 0); chk(d[15:0], 16'h4000);
    acc(1, OFS_DATA_LO, SIZE_DWORD, 0); chk(d, 32'h0302_0100);
    acc(1, OFS_DATA_LO, SIZE_BYTE, 0); chk(d[7:0], 8'h04);
    acc(1, OFS_DATA_HI, SIZE_WORD, 0); chk(d[15:0], 16'h0807);
    acc(1, OFS_RX_PTR, SIZE_WORD, 0); chk(d[15:0], 16'h4007);
    acc(0, OFS_RX_PTR, SIZE_WORD, 32'h0000_0010);
    acc(1, OFS_DATA_LO, SIZE_WORD, 0); chk(d[15:0], 16'h1110);
    acc(1, OFS_RX_PTR, SIZE_WORD, 0); chk(d[15:0], 16'h0010);
    acc(0, OFS_TX_PTR, SIZE_WORD, 32'h0000_4010);
    acc(0, OFS_DATA_LO, SIZE_DWORD, 32'h1234_5678);
    chk(t.data, 32'h1234_5678);
    chk({t.addr, t.lanes}, {11'h010, 4'hF});
    acc(0, OFS_DATA_HI, SIZE_WORD, 32'h0000_9ABC);
    chk(t.data[15:0], 16'h9ABC);
    chk({t.addr, t.lanes}, {11'h016, 4'h3});
    acc(1, OFS_TX_PTR, SIZE_WORD, 0);
    chk(d[15:0], 16'h4016);
    acc(0, OFS_TX_CMD, SIZE_WORD, 32'h0000_0001);
    acc(0, OFS_RX_CMD, SIZE_WORD, 32'h0000_0001);
    acc(1, OFS_RX_CMD, SIZE_WORD, 0); chk(d[0], 1'b1);
    repeat (8) @(posedge clock);
    acc(1, OFS_RX_CMD, SIZE_WORD, 0); chk(d[0], 1'b0);
    acc(1, OFS_RX_PTR, SIZE_WORD, 0); chk(d[15:0], 16'h0123);
    acc(1, OFS_TX_PTR, SIZE_WORD, 0);
    chk(d[15:0], 16'h4040);
    acc(1, 4'hE, SIZE_WORD, 0); chk(d, 32'h0000_0000);
    summarize;
  end
  initial begin
    #3000;
    num_errors++;
    summarize;
  end
endmodule
